// ==== rtl/lcap_core.sv ====
`timescale 1ns/10ps

// ***************************************************************
// Write beat buffer
// ***************************************************************
module lcap_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input  wire logic         clk_i,
    input  wire logic         arst_n_i,
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    output logic              out_valid_o,
    output logic [W-1:0]      out_data_o,
    input  wire logic         out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [W-1:0]  buf_r [0:DEPTH-1];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    logic          push;
    logic          pop;

    // Honest flags straight from the occupancy count
    assign in_ready_o  = (cnt_r != FULL_CNT);
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o  = buf_r[rp_r];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // Pointers and count
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) wp_r <= wp_r + 1'b1;
            if (pop)  rp_r <= rp_r + 1'b1;
            if (push && !pop)      cnt_r <= cnt_r + 1'b1;
            else if (pop && !push) cnt_r <= cnt_r - 1'b1;
        end
    end

    // Storage needs no reset
    always_ff @(posedge clk_i) begin
        if (push) buf_r[wp_r] <= in_data_i;
    end
endmodule : lcap_fifo

module lcap_core
    import lcap_pkg::*;
(
    input  wire logic              core_clk_i,
    input  wire logic              arst_n_i,
    input  wire logic              ck_i,
    input  wire logic              cs_n_i,
    input  wire logic [CA_W-1:0]   ca_i,
    input  wire logic [DQ_W-1:0]   dq_i,
    input  wire logic              dqs_i,
    input  wire logic [DM_W-1:0]   dm_i,
    input  wire logic [1:0]        bl_code_i,
    input  wire logic [3:0]        lat_code_i,
    output logic      [DQ_W-1:0]   dq_o,
    output logic                   dq_oe_n_o,
    output logic                   dqs_o,
    output logic                   dqs_oe_n_o,
    output logic      [NBANK-1:0]  bank_open_o,
    output logic                   lat_err_o,
    output logic                   wr_drop_o
);
    // ***************************************************************
    // Input synchronisers and edge detection
    // ***************************************************************
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    logic              ck_d_r;
    logic              dqs_d_r;
    logic              ck_s;
    logic              cs_n_s;
    logic [CA_W-1:0]   ca_s;
    logic [DQ_W-1:0]   dq_s;
    logic              dqs_s;
    logic [DM_W-1:0]   dm_s;
    logic              ck_rise;
    logic              ck_fall;
    logic              dqs_edge;

    // All link pins cross in two flops, as one vector; bl_code_i and lat_code_i do not
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1_r <= '0;
            sync2_r <= '0;
            ck_d_r  <= 1'b0;
            dqs_d_r <= 1'b0;
        end else begin
            sync1_r <= {ck_i, cs_n_i, ca_i, dq_i, dqs_i, dm_i};
            sync2_r <= sync1_r;
            ck_d_r  <= ck_s;
            dqs_d_r <= dqs_s;
        end
    end

    assign {ck_s, cs_n_s, ca_s, dq_s, dqs_s, dm_s} = sync2_r;
    assign ck_rise  = ck_s & ~ck_d_r;
    assign ck_fall  = ~ck_s & ck_d_r;
    assign dqs_edge = dqs_s ^ dqs_d_r;

    // ***************************************************************
    // Configuration
    // ***************************************************************
    logic [8:0]        lat_dec;
    logic              lat_ok;
    logic [3:0]        rl;
    logic [3:0]        wl;
    logic [BEAT_W-1:0] bl_beats;
    logic [BEAT_W-1:0] rap_wait;
    logic [COL_W-1:0]  col_mask;

    assign lat_dec = lcap_lat_decode(lat_code_i);
    assign {lat_ok, rl, wl} = lat_dec;
    assign col_mask = bl_beats[COL_W-1:0] - 1'b1;

    always_comb begin
        case (bl_code_i)
            LCAP_BL4: bl_beats = BEATS_BL4;
            LCAP_BL8: bl_beats = BEATS_BL8;
            default:  bl_beats = BEATS_BL16;
        endcase
    end

    // Read auto precharge waits the larger of BL/2 and tRTP
    assign rap_wait = ({1'b0, bl_beats[BEAT_W-1:1]} > BEAT_W'(RTP_CK))
                    ? {1'b0, bl_beats[BEAT_W-1:1]} : BEAT_W'(RTP_CK);

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) lat_err_o <= 1'b0;
        else           lat_err_o <= ~lat_ok;
    end

    // ***************************************************************
    // Command decode and latency pipeline
    // ***************************************************************
    logic         colp_v_r;
    lcap_cmd_type colp_r;
    lcap_cmd_type hold_r;
    lcap_cmd_type pipe_r [1:LAT_MAX];
    logic         pre_hit;
    logic         rd_tap;
    logic         wr_tap;
    lcap_cmd_type rd_cmd;
    lcap_cmd_type wr_cmd;

    assign pre_hit = ck_rise & ~cs_n_s & (ca_s[3:0] == PRE_OP);
    // Stage k only fills at the k-th rise, so the latency tap reads one
    // stage earlier; WL1 has no earlier stage and taps the held command
    assign rd_cmd  = pipe_r[rl - 4'h1];
    assign wr_cmd  = (wl == 4'h1) ? hold_r : pipe_r[wl - 4'h1];
    assign rd_tap  = ck_rise & rd_cmd.v & rd_cmd.rd;
    assign wr_tap  = ck_rise & wr_cmd.v & ~wr_cmd.rd;

    // Rising half then falling half; reserved latency blocks column commands
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            colp_v_r <= 1'b0;
            colp_r   <= '0;
            hold_r   <= '0;
        end else begin
            if (ck_rise) begin
                hold_r.v <= 1'b0;
                colp_v_r <= ~cs_n_s & (ca_s[1:0] == COL_OP) & lat_ok;
                colp_r.rd   <= ca_s[CA_RDSEL];
                colp_r.bank <= ca_s[CA_BA_LSB +: BANK_W];
                colp_r.col  <= {1'b0, ca_s[CA_C2R], ca_s[CA_C1R], 1'b0};
            end else if (ck_fall && colp_v_r) begin
                colp_v_r    <= 1'b0;
                hold_r      <= colp_r;
                hold_r.v    <= 1'b1;
                hold_r.ap   <= ca_s[CA_APF];
                hold_r.col[COL_W-1] <= ca_s[CA_C3F];
            end
        end
    end

    // One stage per CK rising edge since the command
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 1; i <= LAT_MAX; i++) pipe_r[i] <= '0;
        end else if (ck_rise) begin
            pipe_r[1] <= hold_r;
            for (int i = 2; i <= LAT_MAX; i++) pipe_r[i] <= pipe_r[i-1];
        end
    end

    // ***************************************************************
    // Array, one byte lane per generated slice
    // ***************************************************************
    logic [ADDR_W-1:0]             rd_addr;
    logic [DQ_W-1:0]               rd_word;
    logic                          drain_v;
    logic                          drain_rdy;
    logic [ADDR_W+DQ_W+DM_W-1:0]   drain_d;
    logic [ADDR_W-1:0]             drain_a;
    logic [DQ_W-1:0]               drain_dq;
    logic [DM_W-1:0]               drain_dm;

    assign {drain_a, drain_dq, drain_dm} = drain_d;

    for (genvar g = 0; g < DM_W; g++) begin : g_lane
        logic [BYTE_W-1:0] lane_r [0:MEM_WORDS-1];
        // Masked bytes keep their old contents
        always_ff @(posedge core_clk_i) begin
            if (drain_v && drain_rdy && !drain_dm[g])
                lane_r[drain_a] <= drain_dq[g*BYTE_W +: BYTE_W];
        end
        assign rd_word[g*BYTE_W +: BYTE_W] = lane_r[rd_addr];
    end

    // ***************************************************************
    // Read data and strobe sequencer
    // ***************************************************************
    lcap_rd_type       rd_st_r;
    logic [BEAT_W-1:0] rd_beat_r;
    logic [BEAT_W-1:0] rd_len_r;
    logic [BANK_W-1:0] rd_bank_r;
    logic [COL_W-1:0]  rd_col_r;
    logic [COL_W-1:0]  rd_mask_r;
    logic              rd_emit;
    logic              rd_last;

    // Sequential wrap inside the burst-aligned column group
    assign rd_addr = {rd_bank_r, (rd_col_r & ~rd_mask_r)
                     | ((rd_col_r + rd_beat_r[COL_W-1:0]) & rd_mask_r)};
    assign rd_emit = (ck_fall && (rd_st_r == RD_PRE || rd_st_r == RD_DATA))
                   || (ck_rise && rd_st_r == RD_DATA);
    assign rd_last = (rd_beat_r + 1'b1 == rd_len_r);

    // Beats go out on every CK edge; even beats raise the strobe
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_st_r    <= RD_IDLE;
            rd_beat_r  <= '0;
            rd_len_r   <= BEATS_BL4;
            rd_bank_r  <= '0;
            rd_col_r   <= '0;
            rd_mask_r  <= '0;
            dq_o       <= '0;
            dqs_o      <= 1'b0;
            dq_oe_n_o  <= 1'b1;
            dqs_oe_n_o <= 1'b1;
        end else begin
            if (rd_emit) begin
                dq_o      <= rd_word;
                dqs_o     <= ~rd_beat_r[0];
                dq_oe_n_o <= 1'b0;
                rd_beat_r <= rd_beat_r + 1'b1;
            end
            case (rd_st_r)
                RD_PRE: begin
                    if (ck_fall) rd_st_r <= RD_DATA;
                end
                RD_DATA: begin
                    if (ck_rise && rd_last && !rd_tap) rd_st_r <= RD_POST;
                end
                RD_POST: begin
                    if (ck_fall) begin
                        rd_st_r    <= RD_IDLE;
                        dq_oe_n_o  <= 1'b1;
                        dqs_oe_n_o <= 1'b1;
                    end
                end
                default: ;
            endcase
            if (rd_tap) begin
                // A later read cuts the running burst at this edge
                rd_beat_r <= '0;
                rd_len_r  <= bl_beats;
                rd_bank_r <= rd_cmd.bank;
                rd_col_r  <= rd_cmd.col;
                rd_mask_r <= col_mask;
                if (rd_st_r != RD_DATA) begin
                    rd_st_r    <= RD_PRE;
                    dqs_o      <= 1'b0;
                    dqs_oe_n_o <= 1'b0;
                end else begin
                    rd_st_r <= RD_DATA;
                end
            end
        end
    end

    // ***************************************************************
    // Write capture into the beat buffer
    // ***************************************************************
    logic              wr_act_r;
    logic [BEAT_W-1:0] wr_beat_r;
    logic [BEAT_W-1:0] wr_len_r;
    logic [BANK_W-1:0] wr_bank_r;
    logic [COL_W-1:0]  wr_col_r;
    logic [COL_W-1:0]  wr_mask_r;
    logic              wr_ap_r;
    logic              wap_pend_r;
    logic [BANK_W-1:0] wap_bank_r;
    logic              push_v;
    logic              push_rdy;
    logic [ADDR_W-1:0] wr_addr;

    assign wr_addr = {wr_bank_r, (wr_col_r & ~wr_mask_r)
                     | ((wr_col_r + wr_beat_r[COL_W-1:0]) & wr_mask_r)};
    assign push_v  = wr_act_r & dqs_edge & ~wr_tap;

    // Each strobe edge in the window is one beat
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_act_r   <= 1'b0;
            wr_beat_r  <= '0;
            wr_len_r   <= BEATS_BL4;
            wr_bank_r  <= '0;
            wr_col_r   <= '0;
            wr_mask_r  <= '0;
            wr_ap_r    <= 1'b0;
            wap_pend_r <= 1'b0;
            wap_bank_r <= '0;
        end else begin
            if (wr_tap) begin
                wr_act_r  <= 1'b1;
                wr_beat_r <= '0;
                wr_len_r  <= bl_beats;
                wr_bank_r <= wr_cmd.bank;
                wr_col_r  <= wr_cmd.col;
                wr_mask_r <= col_mask;
                wr_ap_r   <= wr_cmd.ap;
            end else if (push_v) begin
                wr_beat_r <= wr_beat_r + 1'b1;
                if (wr_beat_r + 1'b1 == wr_len_r) begin
                    wr_act_r <= 1'b0;
                    if (wr_ap_r) begin
                        wap_pend_r <= 1'b1;
                        wap_bank_r <= wr_bank_r;
                    end
                end
            end
            // Closes only once the buffer has emptied into the array
            if (wap_pend_r && !drain_v) wap_pend_r <= 1'b0;
        end
    end

    // Overrun is visible: the link cannot be stalled by the device
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i)                wr_drop_o <= 1'b0;
        else if (push_v && !push_rdy) wr_drop_o <= 1'b1;
    end

    // Array has one port, so a read beat fetch stalls draining
    assign drain_rdy = ~rd_emit;

    lcap_fifo #(
        .W     (ADDR_W + DQ_W + DM_W),
        .DEPTH (FIFO_DEPTH)
    ) u_wbuf (
        .clk_i       (core_clk_i),
        .arst_n_i    (arst_n_i),
        .in_valid_i  (push_v),
        .in_data_i   ({wr_addr, dq_s, dm_s}),
        .in_ready_o  (push_rdy),
        .out_valid_o (drain_v),
        .out_data_o  (drain_d),
        .out_ready_i (drain_rdy)
    );

    // ***************************************************************
    // Bank state: explicit and auto precharge
    // ***************************************************************
    logic              rap_v_r;
    logic [BEAT_W-1:0] rap_cnt_r;
    logic [BANK_W-1:0] rap_bank_r;
    logic              hold_new;

    assign hold_new = ck_fall & colp_v_r;

    // Read auto precharge counts CK rising edges after the command
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rap_v_r    <= 1'b0;
            rap_cnt_r  <= '0;
            rap_bank_r <= '0;
        end else if (hold_new && colp_r.rd && ca_s[CA_APF]) begin
            rap_v_r    <= 1'b1;
            rap_cnt_r  <= rap_wait;
            rap_bank_r <= colp_r.bank;
        end else if (ck_rise && rap_v_r) begin
            rap_cnt_r <= rap_cnt_r - 1'b1;
            if (rap_cnt_r == BEAT_W'(1)) rap_v_r <= 1'b0;
        end
    end

    // Closes first, then an access to a bank marks it open
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bank_open_o <= '0;
        end else begin
            for (int b = 0; b < NBANK; b++) begin
                if (pre_hit && (ca_s[CA_ALLB]
                    || ca_s[CA_BA_LSB +: BANK_W] == BANK_W'(b)))
                    bank_open_o[b] <= 1'b0;
                else if (ck_rise && rap_v_r && rap_cnt_r == BEAT_W'(1)
                         && rap_bank_r == BANK_W'(b))
                    bank_open_o[b] <= 1'b0;
                else if (wap_pend_r && !drain_v
                         && wap_bank_r == BANK_W'(b))
                    bank_open_o[b] <= 1'b0;
                if (hold_new && colp_r.bank == BANK_W'(b))
                    bank_open_o[b] <= 1'b1;
            end
        end
    end
endmodule : lcap_core

// ==== inc/lcap_pkg.sv ====
package lcap_pkg;

    // ***************************************************************
    // Widths and geometry
    // ***************************************************************
    localparam int DQ_W       = 16;
    localparam int DM_W       = 2;
    localparam int BYTE_W     = 8;
    localparam int CA_W       = 10;
    localparam int BANK_W     = 3;
    localparam int COL_W      = 4;
    localparam int NBANK      = 8;
    localparam int ADDR_W     = BANK_W + COL_W;
    localparam int MEM_WORDS  = 1 << ADDR_W;
    localparam int LAT_MAX    = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int BEAT_W     = 5;
    localparam int SYNC_W     = 2 + CA_W + DQ_W + 1 + DM_W;

    // ***************************************************************
    // Command/address bit positions and opcodes
    // ***************************************************************
    localparam int CA_RDSEL   = 2;   // Rising: read when high
    localparam int CA_ALLB    = 4;   // Rising: precharge all banks
    localparam int CA_C1R     = 5;
    localparam int CA_C2R     = 6;
    localparam int CA_BA_LSB  = 7;
    localparam int CA_APF     = 0;   // Falling: auto precharge
    localparam int CA_C3F     = 1;
    localparam logic [1:0] COL_OP = 2'h1;  // {CA1,CA0}
    localparam logic [3:0] PRE_OP = 4'hb;  // {CA3,CA2,CA1,CA0}

    // ***************************************************************
    // Burst length and latency pairs
    // ***************************************************************
    typedef enum logic [1:0] {
        LCAP_BL4  = 2'b00,
        LCAP_BL8  = 2'b01,
        LCAP_BL16 = 2'b10
    } lcap_bl_type;

    localparam logic [BEAT_W-1:0] BEATS_BL4  = 5'h04;
    localparam logic [BEAT_W-1:0] BEATS_BL8  = 5'h08;
    localparam logic [BEAT_W-1:0] BEATS_BL16 = 5'h10;

    // Returns {valid, rl[3:0], wl[3:0]}
    function automatic logic [8:0] lcap_lat_decode(input logic [3:0] code);
        case (code)
            4'h1:    lcap_lat_decode = {1'b1, 4'h3, 4'h1};
            4'h2:    lcap_lat_decode = {1'b1, 4'h4, 4'h2};
            4'h3:    lcap_lat_decode = {1'b1, 4'h5, 4'h2};
            4'h4:    lcap_lat_decode = {1'b1, 4'h6, 4'h3};
            4'h5:    lcap_lat_decode = {1'b1, 4'h7, 4'h4};
            4'h6:    lcap_lat_decode = {1'b1, 4'h8, 4'h4};
            default: lcap_lat_decode = {1'b0, 4'h3, 4'h1};
        endcase
    endfunction : lcap_lat_decode

    // ***************************************************************
    // Timing, in nanoseconds and link clock periods
    // ***************************************************************
    localparam int T_CK_NS    = 800;
    localparam int T_RTP_NS   = 15;
    localparam int RTP_RAW    = (T_RTP_NS + T_CK_NS - 1) / T_CK_NS;
    localparam int RTP_CK     = (RTP_RAW < 1) ? 1 : RTP_RAW;

    // ***************************************************************
    // Read output sequencer and command record
    // ***************************************************************
    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_PRE  = 2'b01,
        RD_DATA = 2'b10,
        RD_POST = 2'b11
    } lcap_rd_type;

    typedef struct packed {
        logic              v;
        logic              rd;
        logic              ap;
        logic [BANK_W-1:0] bank;
        logic [COL_W-1:0]  col;
    } lcap_cmd_type;

endpackage : lcap_pkg

// ==== testbench/lcap_ctrl_model.sv ====
`timescale 1ns/10ps
// ********************
// Controller side model
// ********************
module lcap_ctrl_model (
    input  wire logic  core_clk_i,
    output logic       ck_o,
    output logic       cs_n_o,
    output logic [9:0] ca_o,
    output logic [15:0] dq_o,
    output logic       dqs_o,
    output logic [1:0] dm_o
);
    logic [17:0] beats[$];
    int          wl   = 1;
    int          wcnt = 99;
    bit          send = 0;
    initial {ck_o, cs_n_o, ca_o, dq_o, dqs_o, dm_o} = 31'h20000000;
    // Half link clock; idle data lines toggle, never hold the last beat
    task automatic half(input logic cs, logic [9:0] c, logic e);
        logic tog;
        tog = send && beats.size() > 0;
        cs_n_o = cs;
        ca_o = c;
        if (tog) {dm_o, dq_o} = beats.pop_front();
        else dq_o = ~dq_o;
        repeat (2) @(negedge core_clk_i);
        ck_o = e;
        if (tog) dqs_o = ~dqs_o;
        repeat (2) @(negedge core_clk_i);
    endtask : half
    // One link cycle; strobe stays low as preamble until WL rises pass
    task automatic cyc(input logic cs, logic [9:0] r, logic [9:0] f);
        wcnt = (!cs && r[2:0] == 3'h1) ? 0 : wcnt + 1;
        if (wcnt == 0) send = 0;
        half(cs, r, 1'b1);
        if (wcnt == wl) send = 1;
        half(1'b1, f, 1'b0);
    endtask : cyc
endmodule : lcap_ctrl_model

// ==== testbench/lcap_checker.sv ====
`timescale 1ns/10ps
// ********************
// Port checker
// ********************
module lcap_checker
    import lcap_pkg::*;
(
    input wire logic            core_clk_i,
    input wire logic            arst_n_i,
    input wire logic            ck_i,
    input wire logic            dqs_i,
    input wire logic [3:0]      lat_code_i,
    input wire logic [DQ_W-1:0] dq_o,
    input wire logic            dq_oe_n_o,
    input wire logic            dqs_o,
    input wire logic            dqs_oe_n_o,
    input wire logic [NBANK-1:0] bank_open_o,
    input wire logic            lat_err_o,
    input wire logic            wr_drop_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    logic [3:0] quiet_r;
    // Cycles since a link edge; bank state needs a recent cause
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) quiet_r <= 4'h0;
        else if ($changed(ck_i) || $changed(dqs_i)) quiet_r <= 4'h0;
        else if (quiet_r != 4'hf) quiet_r <= quiet_r + 4'h1;
    end
    lat_flag_a: assert property (
        lat_err_o == !($past(lat_code_i) inside {[1:6]})) else $error("lat");
    pre_low_a: assert property ($fell(dqs_oe_n_o) |->
        (!dqs_o && dq_oe_n_o) [*3]) else $error("preamble");
    first_rise_a: assert property (
        $fell(dq_oe_n_o) |-> $rose(dqs_o)) else $error("first beat");
    beat_hold_a: assert property (!dq_oe_n_o && $past(!dq_oe_n_o) &&
        $stable(dqs_o) |-> $stable(dq_o)) else $error("beat hold");
    strobe_data_a: assert property (
        !dq_oe_n_o |-> !dqs_oe_n_o) else $error("no strobe");
    release_pair_a: assert property (
        $rose(dq_oe_n_o) |-> $rose(dqs_oe_n_o)) else $error("release");
    drop_sticky_a: assert property (
        $past(wr_drop_o) |-> wr_drop_o) else $error("drop");
    bank_cause_a: assert property (
        $changed(bank_open_o) |-> quiet_r < 4'hb) else $error("bank");
endmodule : lcap_checker
bind lcap_core lcap_checker lcap_checker_i (.core_clk_i, .arst_n_i, .ck_i,
    .dqs_i, .lat_code_i, .dq_o, .dq_oe_n_o, .dqs_o, .dqs_oe_n_o,
    .bank_open_o, .lat_err_o, .wr_drop_o);

// ==== testbench/testbench.sv ====
`timescale 1ns/10ps
// ********************
// Bench top
// ********************
module testbench import lcap_pkg::*;;
    logic clk = 0, rst_n = 0, ck, cs_n, dqs, dqso, dqoe, dqsoe, lerr, drop;
    logic pdqs;
    logic [9:0]  ca;
    logic [15:0] dq, dqo, mem [128], exp_q[$];
    logic [1:0]  dm, bl = 2'h0;
    logic [3:0]  lat = 4'h1;
    logic [7:0]  bopen, open_e = 8'h00;
    int err_total, total_checks, bn = 4, wl_t[7] = '{0, 1, 2, 2, 3, 4, 4};
    lcap_core lcap_core_i (.core_clk_i(clk), .arst_n_i(rst_n), .ck_i(ck),
        .cs_n_i(cs_n), .ca_i(ca), .dq_i(dq), .dqs_i(dqs), .dm_i(dm),
        .bl_code_i(bl), .lat_code_i(lat), .dq_o(dqo), .dq_oe_n_o(dqoe),
        .dqs_o(dqso), .dqs_oe_n_o(dqsoe), .bank_open_o(bopen),
        .lat_err_o(lerr), .wr_drop_o(drop));
    lcap_ctrl_model lcap_ctrl_model_i (.core_clk_i(clk), .ck_o(ck),
        .cs_n_o(cs_n), .ca_o(ca), .dq_o(dq), .dqs_o(dqs), .dm_o(dm));
    initial forever #50 clk = ~clk;
    task automatic check(input string nm, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    // Every strobe change while data is driven is one read beat
    always @(negedge clk) begin
        if (!dqoe && dqso !== pdqs)
            check("beat", dqo, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
        pdqs <= dqso;
    end
    // Sequential wrap inside the burst-aligned group
    function automatic logic [6:0] adr(input logic [2:0] b, logic [3:0] c,
                                       int i);
        logic [3:0] k;
        k = 4'(bn - 1);
        adr = {b, (c & ~k) | ((c + 4'(i)) & k)};
    endfunction : adr
    task automatic nop(input int n);
        repeat (n) lcap_ctrl_model_i.cyc(1'b1, ~ca, ~ca);
    endtask : nop
    // Column access; reads queue only the beats that survive a cut
    task automatic acc(input logic rd, logic [2:0] b, logic [3:0] c,
                       logic ap, int n);
        logic [15:0] d;
        logic [1:0]  m;
        for (int i = 0; i < n; i++) begin
            d = 16'($urandom);
            m = 2'($urandom);
            if (rd) exp_q.push_back(mem[adr(b, c, i)]);
            else begin
                if (!m[0]) mem[adr(b, c, i)][7:0] = d[7:0];
                if (!m[1]) mem[adr(b, c, i)][15:8] = d[15:8];
                lcap_ctrl_model_i.beats.push_back({m, d});
            end
        end
        open_e[b] = !ap;
        lcap_ctrl_model_i.cyc(1'b0, {b, c[2:1], 2'h0, rd, 2'h1},
                              {8'h00, c[3], ap});
    endtask : acc
    task automatic pre(input logic all, logic [2:0] b);
        if (all) open_e = 8'h00;
        else open_e[b] = 1'b0;
        lcap_ctrl_model_i.cyc(1'b0, {b, 2'h0, all, 4'hb}, ~ca);
        nop(2);
        check("open", 16'(bopen), 16'(open_e));
    endtask : pre
    // Hang guard
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        end_sim();
    end
    // Main sequence
    initial begin
        void'($urandom(9648));
        repeat (2) @(negedge clk);
        rst_n = 1;
        repeat (4) @(negedge clk);
        for (int i = 0; i < 16; i++) begin
            lat = 4'(i);
            repeat (2) @(negedge clk);
            check("lat", 16'(lerr), 16'(i < 1 || i > 6));
        end
        for (int i = 1; i < 7; i++) begin
            lat = 4'(i);
            lcap_ctrl_model_i.wl = wl_t[i];
            acc(0, 3'(i), 4'(2 * i), 0, 4);
            nop(9);
            acc(1, 3'(i), 4'(2 * i), 0, 4);
            nop(14);
        end
        bl = 2'h1;
        bn = 8;
        acc(0, 3'h2, 4'h0, 0, 8);
        nop(9);
        acc(1, 3'h2, 4'h4, 0, 4);
        nop(1);
        acc(1, 3'h2, 4'h0, 0, 8);
        nop(3);
        acc(1, 3'h2, 4'h6, 1, 8);
        nop(14);
        bl = 2'h2;
        bn = 16;
        acc(0, 3'h5, 4'ha, 1, 16);
        nop(14);
        check("open", 16'(bopen), 16'(open_e));
        acc(1, 3'h5, 4'ha, 0, 16);
        nop(18);
        pre(0, 3'h5);
        pre(1, 3'h0);
        check("drop", 16'(drop), 16'h0);
        check("left", 16'(exp_q.size()), 16'h0);
        end_sim();
    end
endmodule : testbench
